// File: rtl/ipv_pkg.sv
// Overview of operation
// - Eight 16-bit read/write priority registers A-H
// - Four 4-bit fields per register
// - Field code 0 lowest, 15 highest level
// - Shared field gives same level to all
// - Reset clears all priority registers to zero
// - Standby leaves register contents unchanged
// - Register A fields serve pins 0-3
// - Register B low fields serve pins 6, 7
// - Register C upper fields serve DMA 0, 1
// - Register D serves timer 0 and timer 1
// - Register E upper fields serve timer 2
// - Register F low fields serve serial 0, 1
// - Register G serves converter, compare timers
// - Register H top field: watchdog and refresh
// - Each source gives its fixed vector number
// - Fixed rank among sources sharing a field
// - Equal levels resolved by fixed default order
// - Level zero masks the source entirely
package ipv_pkg;

   // ==========================================
   // Register map
   localparam int unsigned NUM_REGS = 8;
   localparam int unsigned REG_W = 16;
   localparam int unsigned FIELD_W = 4;
   localparam int unsigned ADDR_W = 8;
   localparam logic [ADDR_W-1:0] PRIO_A_OFFSET = 8'h00;
   localparam logic [ADDR_W-1:0] PRIO_B_OFFSET = 8'h04;
   localparam logic [ADDR_W-1:0] PRIO_C_OFFSET = 8'h08;
   localparam logic [ADDR_W-1:0] PRIO_D_OFFSET = 8'h0C;
   localparam logic [ADDR_W-1:0] PRIO_E_OFFSET = 8'h10;
   localparam logic [ADDR_W-1:0] PRIO_F_OFFSET = 8'h14;
   localparam logic [ADDR_W-1:0] PRIO_G_OFFSET = 8'h18;
   localparam logic [ADDR_W-1:0] PRIO_H_OFFSET = 8'h1C;
   localparam int unsigned IDX_LSB = 2;
   localparam int unsigned IDX_MSB = 4;
   localparam logic [REG_W-1:0] PRIO_RESET = 16'h0000;

   // Writable bits per register; the rest read zero
   localparam logic [REG_W-1:0] WMASK [NUM_REGS] = '{
      16'hFFFF, 16'h00FF, 16'hFF00, 16'hFFFF,
      16'hFF00, 16'h00FF, 16'hF0FF, 16'hF000};

   // ==========================================
   // Sources, in default order (index 0 highest)
   localparam int unsigned NUM_SRC = 34;
   localparam int unsigned VEC_W = 8;
   localparam int unsigned OFS_W = 10;
   localparam logic [FIELD_W-1:0] LEVEL_MASKED = 4'h0;

   // Register index feeding each source
   localparam logic [2:0] SRC_REG [NUM_SRC] = '{
      3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h1,
      3'h2, 3'h2,
      3'h3, 3'h3, 3'h3, 3'h3, 3'h3,
      3'h3, 3'h3, 3'h3, 3'h3,
      3'h4, 3'h4, 3'h4, 3'h4,
      3'h5, 3'h5, 3'h5, 3'h5,
      3'h5, 3'h5, 3'h5, 3'h5,
      3'h6, 3'h6, 3'h6,
      3'h7, 3'h7};

   // Field index within the register, 3 = bits 15-12, 0 = bits 3-0
   localparam logic [1:0] SRC_FLD [NUM_SRC] = '{
      2'h3, 2'h2, 2'h1, 2'h0, 2'h1, 2'h0,
      2'h3, 2'h2,
      2'h3, 2'h3, 2'h3, 2'h3, 2'h2,
      2'h1, 2'h1, 2'h0, 2'h0,
      2'h3, 2'h3, 2'h2, 2'h2,
      2'h1, 2'h1, 2'h1, 2'h1,
      2'h0, 2'h0, 2'h0, 2'h0,
      2'h3, 2'h1, 2'h0,
      2'h3, 2'h3};

   // Fixed vector numbers
   localparam logic [VEC_W-1:0] SRC_VEC [NUM_SRC] = '{
      8'h40, 8'h41, 8'h42, 8'h43, 8'h46, 8'h47,
      8'h48, 8'h4C,
      8'h58, 8'h59, 8'h5A, 8'h5B, 8'h5C,
      8'h60, 8'h61, 8'h64, 8'h65,
      8'h68, 8'h69, 8'h6C, 8'h6D,
      8'h80, 8'h81, 8'h82, 8'h83,
      8'h84, 8'h85, 8'h86, 8'h87,
      8'h88, 8'h90, 8'h94,
      8'h98, 8'h99};

   localparam int unsigned SRC_CONV = 29;
   localparam logic [VEC_W-1:0] CONV_VEC_ALT = 8'h8A;

endpackage

// File: rtl/ipv_interrupt_priority_vector_map.sv
`timescale 1ns/1ns
module ipv_interrupt_priority_vector_map #(
   parameter bit CONV_ALT_VECTOR = 1'b0
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rstn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ipv_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // External request pins, active high request
   input wire logic ext_req0,
   input wire logic ext_req1,
   input wire logic ext_req2,
   input wire logic ext_req3,
   input wire logic ext_req6,
   input wire logic ext_req7,
   // Dma unit
   input wire logic dma0_transfer_end_req,
   input wire logic dma1_transfer_end_req,
   // Multi timer channel 0
   input wire logic timer0_compare_a_req,
   input wire logic timer0_compare_b_req,
   input wire logic timer0_compare_c_req,
   input wire logic timer0_compare_d_req,
   input wire logic timer0_overflow_req,
   // Multi timer channels 1 and 2
   input wire logic timer1_compare_a_req,
   input wire logic timer1_compare_b_req,
   input wire logic timer1_overflow_req,
   input wire logic timer1_underflow_req,
   input wire logic timer2_compare_a_req,
   input wire logic timer2_compare_b_req,
   input wire logic timer2_overflow_req,
   input wire logic timer2_underflow_req,
   // Serial channels
   input wire logic serial0_error_req,
   input wire logic serial0_rx_full_req,
   input wire logic serial0_tx_empty_req,
   input wire logic serial0_tx_end_req,
   input wire logic serial1_error_req,
   input wire logic serial1_rx_full_req,
   input wire logic serial1_tx_empty_req,
   input wire logic serial1_tx_end_req,
   // Converter, compare timers, watchdog, refresh
   input wire logic converter_end_req,
   input wire logic compare_timer0_req,
   input wire logic compare_timer1_req,
   input wire logic watchdog_interval_req,
   input wire logic refresh_compare_req,
   // Toward core exception logic
   output logic core_int_req,
   output logic [ipv_pkg::FIELD_W-1:0] core_int_level,
   output logic [ipv_pkg::VEC_W-1:0] core_int_vector,
   output logic [ipv_pkg::OFS_W-1:0] core_int_offset
);

   // ==========================================
   // Decode helpers
   function automatic logic [ipv_pkg::FIELD_W-1:0] field_of(
      input logic [ipv_pkg::REG_W-1:0] value,
      input logic [1:0] fld
   );
      field_of = value[fld*ipv_pkg::FIELD_W +: ipv_pkg::FIELD_W];
   endfunction

   function automatic logic addr_hit(input logic [ipv_pkg::ADDR_W-1:0] addr);
      addr_hit = (addr <= ipv_pkg::PRIO_H_OFFSET) && (addr[1:0] == 2'h0);
   endfunction

   // ==========================================
   // Register file
   logic [ipv_pkg::REG_W-1:0] prio_r [ipv_pkg::NUM_REGS];
   logic [31:0] prdata_r;
   logic pslverr_r;

   wire [2:0] reg_idx = paddr[ipv_pkg::IDX_MSB:ipv_pkg::IDX_LSB];
   wire setup_phase = psel & ~penable;
   wire access_phase = psel & penable;
   wire hit = addr_hit(paddr);
   wire wr_en = access_phase & pwrite & hit;
   wire [ipv_pkg::REG_W-1:0] rd_value = hit ? prio_r[reg_idx] : ipv_pkg::PRIO_RESET;

   // Zero wait state; read data and error latched at setup
   assign pready = access_phase;
   assign prdata = prdata_r;
   assign pslverr = pslverr_r & access_phase;

   genvar r;
   generate
      for (r = 0; r < ipv_pkg::NUM_REGS; r++) begin : g_reg
         // Only power-on reset reinitialises; no standby term exists
         always_ff @(posedge clock or negedge rstn) begin
            if (!rstn) begin
               prio_r[r] <= ipv_pkg::PRIO_RESET;
            end else if (wr_en && reg_idx == 3'(r)) begin
               prio_r[r] <= pwdata[ipv_pkg::REG_W-1:0] & ipv_pkg::WMASK[r];
            end
         end
      end
   endgenerate

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         prdata_r <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end else if (setup_phase) begin
         prdata_r <= {16'h0000, rd_value};
         pslverr_r <= ~hit;
      end
   end

   // ==========================================
   // Source requests in default order
   wire [ipv_pkg::NUM_SRC-1:0] src_req = {
      refresh_compare_req, watchdog_interval_req,
      compare_timer1_req, compare_timer0_req, converter_end_req,
      serial1_tx_end_req, serial1_tx_empty_req, serial1_rx_full_req, serial1_error_req,
      serial0_tx_end_req, serial0_tx_empty_req, serial0_rx_full_req, serial0_error_req,
      timer2_underflow_req, timer2_overflow_req, timer2_compare_b_req, timer2_compare_a_req,
      timer1_underflow_req, timer1_overflow_req, timer1_compare_b_req, timer1_compare_a_req,
      timer0_overflow_req, timer0_compare_d_req, timer0_compare_c_req,
      timer0_compare_b_req, timer0_compare_a_req,
      dma1_transfer_end_req, dma0_transfer_end_req,
      ext_req7, ext_req6, ext_req3, ext_req2, ext_req1, ext_req0};

   logic [ipv_pkg::FIELD_W-1:0] src_lvl [ipv_pkg::NUM_SRC];
   logic [ipv_pkg::VEC_W-1:0] src_vec [ipv_pkg::NUM_SRC];

   genvar s;
   generate
      for (s = 0; s < ipv_pkg::NUM_SRC; s++) begin : g_src
         // Shared fields feed every attached source
         assign src_lvl[s] = field_of(prio_r[ipv_pkg::SRC_REG[s]],
                                      ipv_pkg::SRC_FLD[s]);
         if (s == ipv_pkg::SRC_CONV) begin : g_conv
            assign src_vec[s] = CONV_ALT_VECTOR ? ipv_pkg::CONV_VEC_ALT
                                                : ipv_pkg::SRC_VEC[s];
         end else begin : g_fix
            assign src_vec[s] = ipv_pkg::SRC_VEC[s];
         end
      end
   endgenerate

   // ==========================================
   // Arbitration
   logic win_req;
   logic [ipv_pkg::FIELD_W-1:0] win_lvl;
   logic [ipv_pkg::VEC_W-1:0] win_vec;

   always_comb begin
      win_req = 1'b0;
      win_lvl = ipv_pkg::LEVEL_MASKED;
      win_vec = '0;
      for (int i = 0; i < ipv_pkg::NUM_SRC; i++) begin
         // Strictly greater keeps the earlier source on a tie
         if (src_req[i] && src_lvl[i] > win_lvl) begin
            win_req = 1'b1;
            win_lvl = src_lvl[i];
            win_vec = src_vec[i];
         end
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         core_int_req <= 1'b0;
         core_int_level <= ipv_pkg::LEVEL_MASKED;
         core_int_vector <= '0;
         core_int_offset <= '0;
      end else begin
         core_int_req <= win_req;
         core_int_level <= win_lvl;
         core_int_vector <= win_vec;
         core_int_offset <= {win_vec, 2'b00};
      end
   end

endmodule

// File: tb/ipv_map_monitor.sv
`timescale 1ns/1ns
module ipv_map_monitor (
   // Clock and reset
   input wire logic clock,
   input wire logic rstn,
   // Apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ipv_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Core side
   input wire logic core_int_req,
   input wire logic [ipv_pkg::FIELD_W-1:0] core_int_level,
   input wire logic [ipv_pkg::VEC_W-1:0] core_int_vector,
   input wire logic [ipv_pkg::OFS_W-1:0] core_int_offset
);
   wire acc = psel && penable;
   wire bad = paddr > 8'h1C || paddr[1:0] != 2'h0;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);
   a_zero_wait: assert property (acc |-> pready)
      else $error("ready missing");
   a_upper_zero: assert property (acc && !pwrite |-> prdata[31:16] == 16'h0000)
      else $error("upper read bits set");
   a_unmapped_err: assert property (acc && bad |-> pslverr)
      else $error("unmapped access not flagged");
   a_mapped_ok: assert property (acc && !bad |-> !pslverr)
      else $error("mapped access flagged");
   a_offset_x4: assert property (core_int_offset == {core_int_vector, 2'h0})
      else $error("offset not vector times four");
   a_idle_zero: assert property (!core_int_req |-> core_int_level == 4'h0
      && core_int_vector == 8'h00)
      else $error("idle outputs not zero");
   a_level_live: assert property (core_int_req |-> core_int_level != ipv_pkg::LEVEL_MASKED
      && core_int_vector >= 8'h40)
      else $error("masked level forwarded");
   a_reset_clear: assert property ($rose(rstn) |-> !core_int_req ##1 !core_int_req)
      else $error("request right after reset");
endmodule
bind ipv_interrupt_priority_vector_map ipv_map_monitor u_mon (.clock, .rstn, .psel, .penable,
   .pwrite, .paddr, .prdata, .pready, .pslverr, .core_int_req, .core_int_level,
   .core_int_vector, .core_int_offset);

// File: tb/ipv_src_model.sv
`timescale 1ns/1ns
module ipv_src_model (
   // Clock
   input wire logic clock,
   // Wanted and driven requests
   input wire logic [33:0] pend,
   output logic [33:0] req
);
   // Sources change just after the edge
   initial req = 34'h0_0000_0000;
   always @(posedge clock) begin
      req <= pend;
   end
endmodule

// File: tb/testbench.sv
`timescale 1ns/1ns
module testbench;
   logic clock = 1'b0;
   logic rstn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [33:0] pend = 34'h0_0000_0000;
   logic [33:0] rq;
   logic [31:0] prdata, rd;
   logic pready, pslverr, core_int_req, er;
   logic [3:0] core_int_level;
   logic [7:0] core_int_vector;
   logic [9:0] core_int_offset;
   int error_cnt = 0;
   int checks = 0;
   ipv_interrupt_priority_vector_map dut (.clock, .rstn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .ext_req0(rq[0]), .ext_req1(rq[1]),
      .ext_req2(rq[2]), .ext_req3(rq[3]), .ext_req6(rq[4]), .ext_req7(rq[5]),
      .dma0_transfer_end_req(rq[6]), .dma1_transfer_end_req(rq[7]),
      .timer0_compare_a_req(rq[8]), .timer0_compare_b_req(rq[9]),
      .timer0_compare_c_req(rq[10]), .timer0_compare_d_req(rq[11]),
      .timer0_overflow_req(rq[12]), .timer1_compare_a_req(rq[13]),
      .timer1_compare_b_req(rq[14]), .timer1_overflow_req(rq[15]),
      .timer1_underflow_req(rq[16]), .timer2_compare_a_req(rq[17]),
      .timer2_compare_b_req(rq[18]), .timer2_overflow_req(rq[19]),
      .timer2_underflow_req(rq[20]), .serial0_error_req(rq[21]), .serial0_rx_full_req(rq[22]),
      .serial0_tx_empty_req(rq[23]), .serial0_tx_end_req(rq[24]), .serial1_error_req(rq[25]),
      .serial1_rx_full_req(rq[26]), .serial1_tx_empty_req(rq[27]), .serial1_tx_end_req(rq[28]),
      .converter_end_req(rq[29]), .compare_timer0_req(rq[30]), .compare_timer1_req(rq[31]),
      .watchdog_interval_req(rq[32]), .refresh_compare_req(rq[33]), .core_int_req,
      .core_int_level, .core_int_vector, .core_int_offset);
   ipv_src_model u_src (.clock, .pend, .req(rq));
   // Second copy with the alternate converter vector, sharing bus and requests
   logic [7:0] alt_vector;
   ipv_interrupt_priority_vector_map #(.CONV_ALT_VECTOR(1'b1)) dut_alt (.clock, .rstn, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata(), .pready(), .pslverr(), .ext_req0(rq[0]),
      .ext_req1(rq[1]), .ext_req2(rq[2]), .ext_req3(rq[3]), .ext_req6(rq[4]), .ext_req7(rq[5]),
      .dma0_transfer_end_req(rq[6]), .dma1_transfer_end_req(rq[7]),
      .timer0_compare_a_req(rq[8]), .timer0_compare_b_req(rq[9]),
      .timer0_compare_c_req(rq[10]), .timer0_compare_d_req(rq[11]),
      .timer0_overflow_req(rq[12]), .timer1_compare_a_req(rq[13]),
      .timer1_compare_b_req(rq[14]), .timer1_overflow_req(rq[15]),
      .timer1_underflow_req(rq[16]), .timer2_compare_a_req(rq[17]),
      .timer2_compare_b_req(rq[18]), .timer2_overflow_req(rq[19]),
      .timer2_underflow_req(rq[20]), .serial0_error_req(rq[21]), .serial0_rx_full_req(rq[22]),
      .serial0_tx_empty_req(rq[23]), .serial0_tx_end_req(rq[24]), .serial1_error_req(rq[25]),
      .serial1_rx_full_req(rq[26]), .serial1_tx_empty_req(rq[27]), .serial1_tx_end_req(rq[28]),
      .converter_end_req(rq[29]), .compare_timer0_req(rq[30]), .compare_timer1_req(rq[31]),
      .watchdog_interval_req(rq[32]), .refresh_compare_req(rq[33]), .core_int_req(),
      .core_int_level(), .core_int_vector(alt_vector), .core_int_offset());
   initial forever #10 clock = ~clock;
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {16'h0000, d};
      @(posedge clock);
      penable <= 1'b1;
      // Only the watchdog ends a wait that never sees ready
      do begin
         @(posedge clock);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic src(input logic [33:0] v);
      @(posedge clock);
      pend <= v;
      repeat (3) @(posedge clock);
      #1;
   endtask
   task automatic t_reset;
      for (int r = 0; r < 8; r++) begin
         apb(1'b0, 8'(r * 4), 16'h0000);
         chk({core_int_req, rd}, 40'h00_0000_0000);
      end
      $display("reset test done");
   endtask
   task automatic t_regs;
      for (int r = 0; r < 8; r++) begin
         apb(1'b1, 8'(r * 4), 16'hFFFF);
         apb(1'b0, 8'(r * 4), 16'h0000);
         chk(rd, {16'h0000, ipv_pkg::WMASK[r]});
      end
      apb(1'b0, 8'h20, 16'h0000);
      chk({er, rd}, {1'b1, 32'h0000_0000});
      apb(1'b1, 8'h02, 16'h1234);
      chk(er, 1'b1);
      apb(1'b0, 8'h00, 16'h0000);
      chk(rd, 32'h0000_FFFF);
      $display("register test done");
   endtask
   task automatic t_map;
      logic [3:0] lv;
      for (int p = 0; p < 2; p++) begin
         for (int r = 0; r < 8; r++) begin
            lv = 4'(r + 1);
            apb(1'b1, 8'(r * 4), (p == 1) ? {lv, lv, lv, lv} : 16'h4321);
         end
         for (int i = 0; i < 34; i++) begin
            lv = (p == 1) ? 4'(ipv_pkg::SRC_REG[i] + 1) : 4'(ipv_pkg::SRC_FLD[i] + 1);
            src(34'h0_0000_0001 << i);
            chk({core_int_req, core_int_vector}, {1'b1, ipv_pkg::SRC_VEC[i]});
            chk(alt_vector, (i == 29) ? 8'h8A : ipv_pkg::SRC_VEC[i]);
            chk(core_int_level, lv);
            chk(core_int_offset, {ipv_pkg::SRC_VEC[i], 2'h0});
         end
      end
      $display("map test done");
   endtask
   task automatic t_rank;
      src(34'h0_0120_0000);
      chk(core_int_vector, 8'h80);
      src(34'h0_0240_0000);
      chk(core_int_vector, 8'h81);
      src(34'h2_0000_0001);
      chk({core_int_level, core_int_vector}, {4'h8, 8'h99});
      apb(1'b1, 8'h1C, 16'h0000);
      src(34'h3_0000_0000);
      chk(core_int_req, 1'b0);
      apb(1'b1, 8'h1C, 16'h5000);
      src(34'h3_0000_0000);
      chk({core_int_level, core_int_vector}, {4'h5, 8'h98});
      src(34'h2_0000_0000);
      chk({core_int_level, core_int_vector}, {4'h5, 8'h99});
      $display("rank test done");
   endtask
   initial begin
      repeat (5) @(posedge clock);
      rstn <= 1'b1;
      t_reset;
      t_regs;
      t_map;
      t_rank;
      // Reset in mid-run must clear registers that now hold values
      @(posedge clock);
      rstn <= 1'b0;
      repeat (2) @(posedge clock);
      rstn <= 1'b1;
      t_reset;
      stop_test;
   end
   initial begin
      #400000;
      error_cnt++;
      stop_test;
   end
endmodule
